/* File: dv/ebr_chk.sv */
// Purpose: Port-level checks for the embedded block RAM
// Assumes: CTRL is shadowed from APB writes seen at the ports
// Notes:   Write data checks apply only to the 128x36 shape
`timescale 1ns/1ps
module ebr_chk (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic [11:0]                paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       wren_a,
  input wire logic                       rden_a,
  input wire logic [3:0]                 byteena_a,
  input wire logic [ebr_pkg::ADDR_W-1:0] addr_a,
  input wire logic [35:0]                data_a,
  input wire logic [35:0]                q_a,
  input wire logic                       wren_b,
  input wire logic                       rden_b,
  input wire logic [35:0]                q_b
);
  typedef struct packed {
    logic [3:0] shape;
    logic       oreg;
  } shadow_type;
  shadow_type sh_reg;
  shadow_type sh_next;
  logic       aw;
  logic       clr_w;
  logic       wide;
  logic       idle;
  assign aw    = psel && penable && pready && pwrite;
  assign clr_w = aw && paddr == ebr_pkg::OFS_CLEAR;
  assign wide  = sh_reg.shape == 4'h8 && !sh_reg.oreg;
  assign idle  = !wren_a && !rden_a && !wren_b && !rden_b;
  always_comb begin
    sh_next = sh_reg;
    if (aw && paddr == ebr_pkg::OFS_CTRL) begin
      sh_next = '{pwdata[3:0], pwdata[6]};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= '{4'h8, 1'b0};
    end else begin
      sh_reg <= sh_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_zero: assert property ($rose(presetn) |-> q_a == 36'h0 && q_b == 36'h0)
    else $error("read data not zero after reset");
  a_write_thru: assert property (wide && wren_a && byteena_a == 4'hF
    |=> q_a == $past(data_a)) else $error("written word not passed to output");
  a_lane_low: assert property (wide && wren_a && byteena_a[0]
    |=> q_a[8:0] == $past(data_a[8:0])) else $error("lane 0 not written");
  a_lane_top: assert property (wide && wren_a && byteena_a[3]
    |=> q_a[35:27] == $past(data_a[35:27])) else $error("lane 3 not written");
  a_out_reg: assert property (sh_reg.shape == 4'h8 && sh_reg.oreg && wren_a
    && byteena_a == 4'hF |-> ##2 q_a == $past(data_a, 2))
    else $error("registered output late or wrong");
  a_read_back: assert property (wide && wren_a && byteena_a == 4'hF ##1 !wren_a
    ##1 (rden_a && !wren_a && addr_a == $past(addr_a, 2)) |=> q_a == $past(data_a, 3))
    else $error("read does not return stored word");
  a_hold_idle: assert property (!sh_reg.oreg && !wren_a && !rden_a && !aw && !$past(aw)
    |=> $stable(q_a)) else $error("output moved without a request");
  a_clear_out: assert property (clr_w && pwdata[1] && idle ##1 idle
    |=> q_a == 36'h0 && q_b == 36'h0) else $error("output clear failed");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
  c_mask: cover property (wide && wren_a && byteena_a == 4'h5);
  c_clear: cover property (clr_w && pwdata[1]);
  c_both: cover property (wren_a && rden_b);
endmodule // ebr_chk
bind embedded_block_ram ebr_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pready, .wren_a, .rden_a, .byteena_a, .addr_a, .data_a, .q_a, .wren_b, .rden_b,
  .q_b);

/* File: dv/ebr_user_model.sv */
// Purpose: Fabric user logic driving both RAM ports
// Assumes: One request per port per step, then an idle cycle
// Notes:   Released data and address lines show the inverse value
`timescale 1ns/1ps
module ebr_user_model (
  input  wire logic pclk,
  output logic        wren_a,
  output logic        rden_a,
  output logic [3:0]  byteena_a,
  output logic [11:0] addr_a,
  output logic [35:0] data_a,
  output logic        wren_b,
  output logic        rden_b,
  output logic [3:0]  byteena_b,
  output logic [11:0] addr_b,
  output logic [35:0] data_b
);
  logic        pw [2] = '{1'b0, 1'b0};
  logic        pr [2] = '{1'b0, 1'b0};
  logic [3:0]  pb [2] = '{4'hF, 4'hF};
  logic [11:0] pa [2] = '{12'h000, 12'h000};
  logic [35:0] pd [2] = '{36'h0, 36'h0};
  initial begin
    {wren_a, rden_a, wren_b, rden_b} = 4'h0;
    {byteena_a, byteena_b} = 8'hFF;
    {addr_a, addr_b, data_a, data_b} = '0;
  end
  task automatic set(input int p, input logic wr, input logic rd, input logic [3:0] be,
                     input logic [11:0] a, input logic [35:0] d);
    pw[p] = wr;
    pr[p] = rd & ~wr;
    pb[p] = be;
    pa[p] = a;
    pd[p] = d;
  endtask
  task automatic step();
    @(posedge pclk);
    {wren_a, rden_a, byteena_a, addr_a, data_a} <= {pw[0], pr[0], pb[0], pa[0], pd[0]};
    {wren_b, rden_b, byteena_b, addr_b, data_b} <= {pw[1], pr[1], pb[1], pa[1], pd[1]};
    @(posedge pclk);
    {wren_a, rden_a, addr_a, data_a} <= {2'b00, ~pa[0], ~pd[0]};
    {wren_b, rden_b, addr_b, data_b} <= {2'b00, ~pa[1], ~pd[1]};
    pw = '{1'b0, 1'b0};
    pr = '{1'b0, 1'b0};
    #1;
  endtask
endmodule // ebr_user_model

/* File: dv/tb_embedded_block_ram.sv */
// Purpose: Self-checking bench for the embedded block RAM
// Assumes: Partner model drives both user ports
// Notes:   Every scenario judges its own results
`timescale 1ns/1ps
module tb_embedded_block_ram;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic        wren_a, rden_a, wren_b, rden_b;
  logic [3:0]  byteena_a, byteena_b;
  logic [11:0] addr_a, addr_b;
  logic [35:0] data_a, data_b, q_a, q_b;
  int          error_cnt;
  int          check_count;
  embedded_block_ram u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .wren_a, .rden_a, .byteena_a, .addr_a, .data_a, .q_a,
    .wren_b, .rden_b, .byteena_b, .addr_b, .data_b, .q_b);
  ebr_user_model u_user (.pclk, .wren_a, .rden_a, .byteena_a, .addr_a, .data_a, .wren_b,
    .rden_b, .byteena_b, .addr_b, .data_b);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp_q(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t q %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t apb %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t apb no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic op(input int p, input logic wr, input logic [3:0] be, input logic [11:0] a,
                    input logic [35:0] d);
    u_user.set(p, wr, !wr, be, a, d);
    u_user.step();
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    cmp_q(q_a, 36'h0);
    cmp_q(q_b, 36'h0);
    apb(1'b0, ebr_pkg::OFS_CTRL, 32'h0, r, e);
    cmp_w(r, 32'h0000_0008);
    apb(1'b0, ebr_pkg::OFS_STATUS, 32'h0, r, e);
    cmp_w(r & 32'h0000_00FF, 32'h0000_00FF);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF, r, e);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    cmp_w(r, 32'h0);
    cmp_w({31'h0, e}, 32'h1);
  endtask
  task automatic t_mask();
    logic [35:0] old;
    logic [35:0] nw;
    logic [3:0]  bes [4] = '{4'h5, 4'hA, 4'h0, 4'h9};
    old = 36'h1_2345_6789;
    op(0, 1'b1, 4'hF, 12'h005, old);
    cmp_q(q_a, old);
    op(0, 1'b0, 4'hF, 12'h005, 36'h0);
    cmp_q(q_a, old);
    foreach (bes[i]) begin
      nw = 36'hA_BCDE_F012 ^ {9{bes[i]}};
      for (int n = 0; n < 4; n++) begin
        if (bes[i][n]) old[9*n +: 9] = nw[9*n +: 9];
      end
      op(0, 1'b1, bes[i], 12'h005, nw);
      cmp_q(q_a, old);
      op(0, 1'b0, 4'hF, 12'h005, 36'h0);
      cmp_q(q_a, old);
    end
  endtask
  task automatic t_modes();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ebr_pkg::OFS_CTRL, 32'h0000_0003, r, e);
    op(0, 1'b1, 4'h0, 12'h003, 36'h0_0000_00A5);
    op(0, 1'b0, 4'h0, 12'h003, 36'h0);
    cmp_q(q_a, 36'h0_0000_00A5);
    // Lane mask of port A is still low here, so the clear is visible
    apb(1'b1, ebr_pkg::OFS_CLEAR, 32'h0000_0001, r, e);
    apb(1'b0, ebr_pkg::OFS_STATUS, 32'h0, r, e);
    cmp_w(r & 32'h0000_03FF, 32'h0000_03FF);
    apb(1'b1, ebr_pkg::OFS_CTRL, 32'h0000_0004, r, e);
    op(0, 1'b1, 4'hF, 12'h011, 36'h0_0000_BEEF);
    op(0, 1'b1, 4'h1, 12'h011, 36'h0_0000_1234);
    cmp_q(q_a, 36'h0_0000_BE34);
    op(0, 1'b0, 4'h0, 12'h011, 36'h0);
    cmp_q(q_a, 36'h0_0000_BE34);
    apb(1'b1, ebr_pkg::OFS_CTRL, 32'h0000_0007, r, e);
    op(0, 1'b1, 4'hF, 12'h012, 36'h0_0003_FFFF);
    op(0, 1'b1, 4'h2, 12'h012, 36'h0);
    op(0, 1'b0, 4'h0, 12'h012, 36'h0);
    cmp_q(q_a, 36'h0_0000_01FF);
    apb(1'b1, ebr_pkg::OFS_CTRL, 32'h0000_0048, r, e);
    op(0, 1'b1, 4'hF, 12'h007, 36'h7_7777_0001);
    @(posedge pclk);
    op(0, 1'b1, 4'hF, 12'h008, 36'h8_8888_0002);
    cmp_q(q_a, 36'h7_7777_0001);
    @(posedge pclk);
    #1;
    cmp_q(q_a, 36'h8_8888_0002);
    apb(1'b1, ebr_pkg::OFS_CLEAR, 32'h0000_0002, r, e);
    @(posedge pclk);
    #1;
    cmp_q(q_a, 36'h0);
  endtask
  task automatic t_ports();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ebr_pkg::OFS_CTRL, 32'h0000_0018, r, e);
    // Both halves use the same low address to expose a missing split
    u_user.set(0, 1'b1, 1'b0, 4'hF, 12'h002, 36'hA_0000_000A);
    u_user.set(1, 1'b1, 1'b0, 4'hF, 12'h002, 36'hB_0000_000B);
    u_user.step();
    u_user.set(0, 1'b0, 1'b1, 4'hF, 12'h002, 36'h0);
    u_user.set(1, 1'b0, 1'b1, 4'hF, 12'h002, 36'h0);
    u_user.step();
    cmp_q(q_a, 36'hA_0000_000A);
    cmp_q(q_b, 36'hB_0000_000B);
    apb(1'b1, ebr_pkg::OFS_CTRL, 32'h0000_0128, r, e);
    op(0, 1'b1, 4'hF, 12'h009, 36'h0_1111_2222);
    for (int k = 0; k < 2; k++) begin
      u_user.set(0, 1'b1, 1'b0, 4'hF, 12'h009, 36'h3_3333_4444);
      u_user.set(1, 1'b0, 1'b1, 4'hF, 12'h009, 36'h0);
      u_user.step();
      cmp_q(q_b, k == 0 ? 36'h0_1111_2222 : 36'h0);
      apb(1'b1, ebr_pkg::OFS_CTRL, 32'h0000_0028, r, e);
    end
  endtask
  initial begin
    {error_cnt, check_count} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    t_mask();
    t_modes();
    t_ports();
    print_verdict();
  end
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule // tb_embedded_block_ram

/* File: verilog/ebr_apb_cfg.sv */
// Purpose: APB slave holding the block configuration and clear controls.
// Assumes: Every transfer sees one setup and one access cycle, no waits.
// Notes:   Read data and error are prepared in the setup cycle.
`timescale 1ns/1ps
module ebr_apb_cfg (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [11:0]        status,
  output ebr_pkg::shape_type      shape,
  output ebr_pkg::mode_type       mode,
  output logic      [1:0]         oreg,
  output logic                    rdw_old,
  output logic                    clr_in,
  output logic                    clr_out
);

  typedef struct packed {
    ebr_pkg::shape_type shape;
    ebr_pkg::mode_type  mode;
    logic [1:0]         oreg;
    logic               rdw_old;
    logic               clr_in;
    logic               clr_out;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } cfg_type;

  cfg_type cfg_reg;
  cfg_type cfg_next;

  localparam int CTRL_SHAPE_LSB_TOP = ebr_pkg::CTRL_SHAPE_LSB + 3;

  always_comb begin
    logic        hit;
    logic [31:0] ctrl;
    ctrl = '0;
    ctrl[CTRL_SHAPE_LSB_TOP:ebr_pkg::CTRL_SHAPE_LSB] = cfg_reg.shape;
    ctrl[ebr_pkg::CTRL_MODE_LSB+1:ebr_pkg::CTRL_MODE_LSB] = cfg_reg.mode;
    ctrl[ebr_pkg::CTRL_OREG_B:ebr_pkg::CTRL_OREG_A] = cfg_reg.oreg;
    ctrl[ebr_pkg::CTRL_RDW_OLD] = cfg_reg.rdw_old;
    hit = paddr == ebr_pkg::OFS_CTRL || paddr == ebr_pkg::OFS_CLEAR
          || paddr == ebr_pkg::OFS_STATUS;
    cfg_next         = cfg_reg;
    cfg_next.clr_in  = 1'b0;
    cfg_next.clr_out = 1'b0;
    cfg_next.pready  = psel && !penable;
    if (psel && !penable) begin
      cfg_next.pslverr = !hit;
      unique case (paddr)
        ebr_pkg::OFS_CTRL:   cfg_next.prdata = ctrl;
        ebr_pkg::OFS_STATUS: cfg_next.prdata = {20'h00000, status};
        default:             cfg_next.prdata = '0;
      endcase
    end
    if (psel && penable && cfg_reg.pready && pwrite) begin
      if (paddr == ebr_pkg::OFS_CTRL) begin
        // Illegal shape or mode codes leave the field unchanged
        if (pwdata[CTRL_SHAPE_LSB_TOP:ebr_pkg::CTRL_SHAPE_LSB] <= 4'(ebr_pkg::SHAPE_128X36))
          cfg_next.shape = ebr_pkg::shape_type'(
            pwdata[CTRL_SHAPE_LSB_TOP:ebr_pkg::CTRL_SHAPE_LSB]);
        if (pwdata[ebr_pkg::CTRL_MODE_LSB+1:ebr_pkg::CTRL_MODE_LSB] <= 2'(ebr_pkg::MODE_DUAL))
          cfg_next.mode = ebr_pkg::mode_type'(
            pwdata[ebr_pkg::CTRL_MODE_LSB+1:ebr_pkg::CTRL_MODE_LSB]);
        cfg_next.oreg    = pwdata[ebr_pkg::CTRL_OREG_B:ebr_pkg::CTRL_OREG_A];
        cfg_next.rdw_old = pwdata[ebr_pkg::CTRL_RDW_OLD];
      end
      if (paddr == ebr_pkg::OFS_CLEAR) begin
        cfg_next.clr_in  = pwdata[ebr_pkg::CLR_IN_BIT];
        cfg_next.clr_out = pwdata[ebr_pkg::CLR_OUT_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg         <= '0;
      cfg_reg.shape   <= ebr_pkg::SHAPE_RESET;
      cfg_reg.mode    <= ebr_pkg::MODE_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign prdata  = cfg_reg.prdata;
  assign pready  = cfg_reg.pready;
  assign pslverr = cfg_reg.pslverr;
  assign shape   = cfg_reg.shape;
  assign mode    = cfg_reg.mode;
  assign oreg    = cfg_reg.oreg;
  assign rdw_old = cfg_reg.rdw_old;
  assign clr_in  = cfg_reg.clr_in;
  assign clr_out = cfg_reg.clr_out;

endmodule // ebr_apb_cfg

/* File: verilog/ebr_lane_map.sv */
// Purpose: Decodes one port's address, data and lane mask into row terms.
// Assumes: Purely combinational; caller registers the results.
// Notes:   Bits outside the addressed word get a zero write mask.
`timescale 1ns/1ps
module ebr_lane_map (
  input  wire ebr_pkg::shape_type              shape,
  input  wire logic                            wr,
  input  wire logic [3:0]                      be,
  input  wire logic [ebr_pkg::ADDR_W-1:0]      addr,
  input  wire logic [35:0]                     din,
  output logic      [ebr_pkg::ROW_AW-1:0]      row,
  output logic      [ebr_pkg::SLOT_W-1:0]      slot,
  output logic      [35:0]                     wmask,
  output logic      [35:0]                     wdata
);

  always_comb begin
    ebr_pkg::map_type m;
    int               sl;
    m     = '0;
    sl    = ebr_pkg::slot_log2(shape);
    row   = ebr_pkg::ROW_AW'(addr >> sl);
    slot  = ebr_pkg::SLOT_W'(addr & ((1 << sl) - 1));
    wmask = '0;
    wdata = '0;
    for (int p = 0; p < ebr_pkg::ROW_BITS; p++) begin
      m = ebr_pkg::map_bit(shape, p);
      if (m.valid && m.slot == slot) begin
        wdata[p] = din[m.bitpos];
        // Narrow widths ignore the mask entirely
        wmask[p] = wr && (ebr_pkg::lanes_log2(shape) == 0 || be[m.lane]);
      end
    end
  end

endmodule // ebr_lane_map

/* File: verilog/ebr_pkg.sv */
// Purpose: Shared constants, types and lane mapping for the embedded block RAM.
// Assumes: One clock, pclk at 125 MHz; APB slave for configuration.
// Notes:   Storage is 128 rows of 36 bits, four 9-bit lanes per row.
// How it works
// - Holds 4,608 bits in total, 512 of them parity bits.
// - One extra bit per byte gives 9, 18, 36 widths; no parity checking.
// - Shapes 4Kx1 through 128x36, nine in all.
// - Outputs read zero after power-up whatever the contents hold.
// - Only enabled byte lanes are written; masked lanes keep old value.
// - Lane mask defaults high; write needs write strobe and mask bit.
// - Clearing read-strobe or lane-mask register drives it high.
// - Byte masking only in 16, 18, 32 and 36 bit widths.
// - 9-bit lanes: mask bit n governs bits 9n+8 down to 9n.
// - Any mask combination allowed; 16 and 32 widths use 8-bit lanes.
// - Inputs are captured at the clock edge; output registered or not.
// - Clearable registers on both the input and output side.
// - Offers single-port, split and dual-port operating modes.
// - Single-port does read or write per cycle, never both.
// - Single-port write passes the written word to the read output.
// - Unregistered output shows the new word at the writing edge.
// - Read of the address another port writes gives unknown or old data.
// - Writes commit on the falling edge, reads happen on the rising edge.
package ebr_pkg;

  localparam int ROWS        = 128;
  localparam int ROW_BITS    = 36;
  localparam int ROW_AW      = 7;
  localparam int ADDR_W      = 12;
  localparam int LANES       = 4;
  localparam int LANE_BITS   = 9;
  localparam int SLOT_W      = 5;
  localparam int TOTAL_BITS  = 4608;
  localparam int PARITY_BITS = 512;
  // Every row carries one parity bit per lane
  localparam int PARITY_CHECK = ROWS * LANES;

  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_CLEAR  = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;

  localparam int CTRL_SHAPE_LSB = 0;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_OREG_A    = 6;
  localparam int CTRL_OREG_B    = 7;
  localparam int CTRL_RDW_OLD   = 8;
  localparam int CLR_IN_BIT     = 0;
  localparam int CLR_OUT_BIT    = 1;
  localparam int ST_BE_B_LSB    = 4;
  localparam int ST_RDEN_A      = 8;
  localparam int ST_RDEN_B      = 9;
  localparam int ST_WR_A        = 10;
  localparam int ST_WR_B        = 11;

  localparam logic [3:0]  BE_DEFAULT  = 4'hF;
  localparam logic [35:0] RDW_UNKNOWN = 36'h0;

  typedef enum logic [3:0] {
    SHAPE_4KX1   = 4'h0,
    SHAPE_2KX2   = 4'h1,
    SHAPE_1KX4   = 4'h2,
    SHAPE_512X8  = 4'h3,
    SHAPE_256X16 = 4'h4,
    SHAPE_128X32 = 4'h5,
    SHAPE_512X9  = 4'h6,
    SHAPE_256X18 = 4'h7,
    SHAPE_128X36 = 4'h8
  } shape_type;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_SPLIT  = 2'h1,
    MODE_DUAL   = 2'h2
  } mode_type;

  localparam shape_type SHAPE_RESET = SHAPE_128X36;
  localparam mode_type  MODE_RESET  = MODE_SINGLE;

  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [5:0]        bitpos;
    logic [1:0]        lane;
  } map_type;

  function automatic logic is_parity(input shape_type s);
    return s >= SHAPE_512X9;
  endfunction

  // Log2 of lanes per word; zero means byte masking is off
  function automatic int lanes_log2(input shape_type s);
    unique case (s)
      SHAPE_256X16, SHAPE_256X18: return 1;
      SHAPE_128X32, SHAPE_128X36: return 2;
      default:                    return 0;
    endcase
  endfunction

  // Log2 of words held in one row
  function automatic int slot_log2(input shape_type s);
    if (is_parity(s))
      return 2 - lanes_log2(s);
    return 5 - int'(s);
  endfunction

  // Where physical row bit p lands in a word of the given shape
  function automatic map_type map_bit(input shape_type s, input int p);
    map_type m;
    int      lane;
    int      inl;
    int      col;
    int      lw;
    lane = p / LANE_BITS;
    inl  = p % LANE_BITS;
    m.valid = 1'b1;
    m.lane  = 2'(lane & ((1 << lanes_log2(s)) - 1));
    if (is_parity(s)) begin
      m.slot   = SLOT_W'(lane >> lanes_log2(s));
      m.bitpos = 6'((lane & ((1 << lanes_log2(s)) - 1)) * LANE_BITS + inl);
    end else begin
      // Ninth bit of each lane is unused without parity
      m.valid  = (inl != LANE_BITS - 1);
      col      = lane * 8 + inl;
      lw       = int'(s);
      m.slot   = SLOT_W'(col >> lw);
      m.bitpos = 6'(col & ((1 << lw) - 1));
    end
    return m;
  endfunction

  function automatic logic [35:0] extract(input shape_type s, input logic [SLOT_W-1:0] slot,
                                          input logic [35:0] row);
    logic [35:0] q;
    map_type     m;
    q = '0;
    for (int p = 0; p < ROW_BITS; p++) begin
      m = map_bit(s, p);
      if (m.valid && m.slot == slot)
        q[m.bitpos] = row[p];
    end
    return q;
  endfunction

endpackage

/* File: verilog/embedded_block_ram.sv */
// Purpose: Embedded block RAM with two user ports and APB configuration.
// Assumes: User inputs are synchronous to pclk; contents are never reset.
// Notes:   Port B is idle in single mode, its own half in split mode,
//          and read-only in dual mode.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module embedded_block_ram (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [11:0]                   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          wren_a,
  input  wire logic                          rden_a,
  input  wire logic [3:0]                    byteena_a,
  input  wire logic [ebr_pkg::ADDR_W-1:0]    addr_a,
  input  wire logic [35:0]                   data_a,
  output logic      [35:0]                   q_a,
  input  wire logic                          wren_b,
  input  wire logic                          rden_b,
  input  wire logic [3:0]                    byteena_b,
  input  wire logic [ebr_pkg::ADDR_W-1:0]    addr_b,
  input  wire logic [35:0]                   data_b,
  output logic      [35:0]                   q_b
);

  typedef struct packed {
    logic [ebr_pkg::ROW_AW-1:0] row;
    logic [ebr_pkg::SLOT_W-1:0] slot;
    logic [35:0]                wmask;
    logic [35:0]                wdata;
    logic                       wr;
    logic                       rden;
    logic [3:0]                 be;
    logic [35:0]                rd;
    logic [35:0]                out;
  } port_type;

  typedef struct packed {
    port_type [1:0] p;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [35:0] mem [ebr_pkg::ROWS];

  ebr_pkg::shape_type shape;
  ebr_pkg::mode_type  mode;
  logic [1:0]         oreg;
  logic               rdw_old;
  logic               clr_in;
  logic               clr_out;
  logic [11:0]        status;

  logic [1:0]                       wr_g;
  logic [1:0]                       rd_g;
  logic [1:0][3:0]                  be_in;
  logic [1:0][ebr_pkg::ADDR_W-1:0]  addr_in;
  logic [1:0][35:0]                 din_in;
  logic [1:0][ebr_pkg::ROW_AW-1:0]  lm_row;
  logic [1:0][ebr_pkg::SLOT_W-1:0]  lm_slot;
  logic [1:0][35:0]                 lm_wmask;
  logic [1:0][35:0]                 lm_wdata;

  ebr_apb_cfg u_cfg (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .status  (status),
    .shape   (shape),
    .mode    (mode),
    .oreg    (oreg),
    .rdw_old (rdw_old),
    .clr_in  (clr_in),
    .clr_out (clr_out)
  );

  // Port roles follow the operating mode
  always_comb begin
    be_in   = {byteena_b, byteena_a};
    addr_in = {addr_b, addr_a};
    din_in  = {data_b, data_a};
    wr_g[0] = wren_a;
    rd_g[0] = rden_a && !wren_a;
    wr_g[1] = wren_b && mode == ebr_pkg::MODE_SPLIT;
    rd_g[1] = rden_b && !wr_g[1] && mode != ebr_pkg::MODE_SINGLE;
  end

  for (genvar i = 0; i < 2; i++) begin : g_port
    ebr_lane_map u_map (
      .shape (shape),
      .wr    (wr_g[i]),
      .be    (be_in[i]),
      .addr  (addr_in[i]),
      .din   (din_in[i]),
      .row   (lm_row[i]),
      .slot  (lm_slot[i]),
      .wmask (lm_wmask[i]),
      .wdata (lm_wdata[i])
    );
  end

  always_comb begin
    logic [ebr_pkg::ROW_AW-1:0] row_eff;
    logic [35:0]                old_row;
    logic [35:0]                merged;
    logic                       clash;
    row_eff    = '0;
    old_row    = '0;
    merged     = '0;
    clash      = 1'b0;
    state_next = state_reg;
    for (int i = 0; i < 2; i++) begin
      row_eff = lm_row[i];
      // Split halves: A owns the low rows, B the high rows
      if (mode == ebr_pkg::MODE_SPLIT)
        row_eff = {1'(i), lm_row[i][ebr_pkg::ROW_AW-2:0]};
      state_next.p[i].row   = row_eff;
      state_next.p[i].slot  = lm_slot[i];
      state_next.p[i].wmask = lm_wmask[i];
      state_next.p[i].wdata = lm_wdata[i];
      state_next.p[i].wr    = wr_g[i];
      state_next.p[i].rden  = rd_g[i] || wr_g[i];
      state_next.p[i].be    = be_in[i];
      // Committed writes of the last cycle are already in the array
      old_row = mem[row_eff];
      merged  = (old_row & ~lm_wmask[i]) | (lm_wdata[i] & lm_wmask[i]);
      if (wr_g[i] || rd_g[i])
        state_next.p[i].rd = ebr_pkg::extract(shape, lm_slot[i], merged);
      // Output register follows only cycles that read or write
      if (state_reg.p[i].rden)
        state_next.p[i].out = state_reg.p[i].rd;
      if (clr_in) begin
        state_next.p[i].be   = ebr_pkg::BE_DEFAULT;
        state_next.p[i].rden = 1'b1;
      end
      if (clr_out) begin
        state_next.p[i].rd  = '0;
        state_next.p[i].out = '0;
      end
    end
    // Mixed-port read of the word port A is writing
    clash = mode == ebr_pkg::MODE_DUAL && wr_g[0] && rd_g[1]
            && lm_row[0] == lm_row[1] && lm_slot[0] == lm_slot[1];
    if (clash && !rdw_old && !clr_out)
      state_next.p[1].rd = ebr_pkg::RDW_UNKNOWN;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      for (int i = 0; i < 2; i++) begin
        state_reg.p[i].be   <= ebr_pkg::BE_DEFAULT;
        state_reg.p[i].rden <= 1'b1;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // Array write half a cycle after the inputs were captured
  always_ff @(negedge pclk) begin
    for (int i = 0; i < 2; i++) begin
      if (|state_reg.p[i].wmask)
        mem[state_reg.p[i].row] <= (mem[state_reg.p[i].row] & ~state_reg.p[i].wmask)
                                   | (state_reg.p[i].wdata & state_reg.p[i].wmask);
    end
  end

  assign q_a = oreg[0] ? state_reg.p[0].out : state_reg.p[0].rd;
  assign q_b = oreg[1] ? state_reg.p[1].out : state_reg.p[1].rd;

  assign status = {state_reg.p[1].wr, state_reg.p[0].wr, state_reg.p[1].rden,
                   state_reg.p[0].rden, state_reg.p[1].be, state_reg.p[0].be};

endmodule // embedded_block_ram
